// ===== hdl/ufu_flash_update_cmd.sv
// Notes on behaviour
// - Eight data bits, LSB first, no parity.
// - Link runs at 115200 bits per second.
// - Start packet: 01, 0002, 02, checksum.
// - Write packet: 01, 0102, 03, 256 bytes.
// - End packet: 01, 0002, 04, checksum.
// - Checksum is sum of command and payload.
// - Acknowledge 0x01 after good start, write.
// - Failure: no ack, error shown, sticky.
// - End command never gets a reply.
// - Start lights indicator, then initialises flash.
// - Shield window forced to blocks 0..63.
// - Write address set to 0x1000 before ack.
// - New block: blank check, erase if needed.
// - Write 256 bytes, advance address by 256.
// - Verify full block, or partial at end.
// - End: verify, invert boot flag, reset.
// - Indicator off before forced reset.
// - Inverted boot flag swaps clusters next reset.
// - Any flash operation failure is sticky error.
// - Idle halted until a character arrives.
`timescale 1ns/10ps
`default_nettype none
module ufu_flash_update_cmd #(
    // Clocks per serial bit; a bench may shorten it to save run time
    parameter int BIT_TICKS = ufu_pkg::BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rxd,
    output logic txd,
    output logic flash_access_led_pin,
    output logic error_flag,
    output logic halt_req,
    output logic force_reset,
    output logic boot_swap_pending,
    output logic fl_req,
    output ufu_pkg::ufu_op_t fl_op,
    output logic [19:0] fl_addr,
    output logic [5:0] fl_block,
    output logic [5:0] fl_shield_first,
    output logic [5:0] fl_shield_last,
    output logic [7:0] fl_wdata,
    output logic [7:0] fl_windex,
    input wire logic fl_done,
    input wire logic fl_fail,
    input wire logic fl_blank,
    input wire logic [5:0] fl_shield_first_rd,
    input wire logic [5:0] fl_shield_last_rd,
    input wire logic boot_flag_rd
);
// ==========================================================
// Receiver
localparam int HALF_TICKS = BIT_TICKS / 2;
logic rx_s1_ff, rx_s2_ff;
logic [15:0] rx_cnt_ff;
logic [3:0] rx_bit_ff;
logic rx_busy_ff;
logic [7:0] rx_sh_ff;
logic rx_vld_ff;
logic [7:0] rx_byte_ff;
// Two stages: the pin is asynchronous to sys_clk
always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        rx_s1_ff <= 1'b1;
        rx_s2_ff <= 1'b1;
    end else begin
        rx_s1_ff <= rxd;
        rx_s2_ff <= rx_s1_ff;
    end
end
always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        rx_busy_ff <= 1'b0;
        rx_cnt_ff <= 16'h0000;
        rx_bit_ff <= 4'h0;
        rx_sh_ff <= 8'h00;
        rx_vld_ff <= 1'b0;
        rx_byte_ff <= 8'h00;
    end else begin
        rx_vld_ff <= 1'b0;
        if (!rx_busy_ff) begin
            if (!rx_s2_ff) begin
                rx_busy_ff <= 1'b1;
                rx_cnt_ff <= 16'(HALF_TICKS);
                rx_bit_ff <= 4'h0;
            end
        end else if (rx_cnt_ff != 16'h0000) begin
            rx_cnt_ff <= rx_cnt_ff - 16'h0001;
        end else begin
            rx_cnt_ff <= 16'(BIT_TICKS - 1);
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'h0) begin
                if (rx_s2_ff) begin
                    rx_busy_ff <= 1'b0; // False start
                end
            end else if (rx_bit_ff <= 4'(ufu_pkg::DATA_BITS)) begin
                rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
            end else begin
                // Stop bit, no parity slot
                rx_busy_ff <= 1'b0;
                rx_vld_ff <= rx_s2_ff;
                rx_byte_ff <= rx_sh_ff;
            end
        end
    end
end
// ==========================================================
// Transmitter
logic tx_go;
logic tx_busy_ff;
logic [15:0] tx_cnt_ff;
logic [3:0] tx_bit_ff;
logic [9:0] tx_sh_ff;
always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        tx_busy_ff <= 1'b0;
        tx_cnt_ff <= 16'h0000;
        tx_bit_ff <= 4'h0;
        tx_sh_ff <= 10'h3FF;
    end else if (tx_go) begin
        tx_busy_ff <= 1'b1;
        tx_cnt_ff <= 16'(BIT_TICKS - 1);
        tx_bit_ff <= 4'h0;
        tx_sh_ff <= {1'b1, ufu_pkg::ACK_BYTE, 1'b0};
    end else if (tx_busy_ff) begin
        if (tx_cnt_ff != 16'h0000) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
        end else begin
            tx_cnt_ff <= 16'(BIT_TICKS - 1);
            tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == 4'h9) begin
                tx_busy_ff <= 1'b0;
            end
        end
    end
end
assign txd = tx_sh_ff[0];
// ==========================================================
// Packet parser and flash sequence
typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_LENH = 5'h01,
    ST_LENL = 5'h03,
    ST_CMD = 5'h02,
    ST_DATA = 5'h06,
    ST_SUM = 5'h07,
    ST_EXEC = 5'h05,
    ST_OP = 5'h04,
    ST_WAIT = 5'h0C,
    ST_NEXT = 5'h0D,
    ST_ACK = 5'h0F,
    ST_RESET = 5'h0E,
    ST_ERR = 5'h0A
} ufu_state_t;
ufu_state_t st_ff;
ufu_pkg::ufu_op_t op_ff;
logic [15:0] len_ff;
logic [7:0] cmd_ff;
logic [7:0] sum_ff;
logic [8:0] idx_ff;
logic [7:0] buf_mem [256];
logic [19:0] addr_ff;
logic blk_open_ff;
logic err_ff, led_ff, rst_ff, req_ff;
logic len_ok, is_fail;
assign len_ok = (len_ff == ufu_pkg::LEN_SHORT && cmd_ff != ufu_pkg::CMD_WRITE)
    || (len_ff == ufu_pkg::LEN_WRITE && cmd_ff == ufu_pkg::CMD_WRITE);
assign is_fail = fl_done && fl_fail;
assign tx_go = (st_ff == ST_ACK) && !tx_busy_ff;
// Payload held until its checksum proves it; 256 entries
always_ff @(posedge sys_clk) begin
    if (st_ff == ST_DATA && rx_vld_ff) begin
        buf_mem[idx_ff[7:0]] <= rx_byte_ff;
    end
end
always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        st_ff <= ST_IDLE;
        op_ff <= ufu_pkg::UFU_OP_NONE;
        len_ff <= 16'h0000;
        cmd_ff <= 8'h00;
        sum_ff <= 8'h00;
        idx_ff <= 9'h000;
        addr_ff <= 20'h00000;
        blk_open_ff <= 1'b0;
        err_ff <= 1'b0;
        led_ff <= 1'b1;
        rst_ff <= 1'b0;
        req_ff <= 1'b0;
    end else begin
        req_ff <= 1'b0;
        case (st_ff)
        ST_IDLE: begin
            if (rx_vld_ff) begin
                if (rx_byte_ff == ufu_pkg::START_CODE) begin
                    st_ff <= ST_LENH;
                end else begin
                    st_ff <= ST_ERR;
                end
            end
        end
        ST_LENH: begin
            if (rx_vld_ff) begin
                len_ff <= {rx_byte_ff, 8'h00};
                st_ff <= ST_LENL;
            end
        end
        ST_LENL: begin
            if (rx_vld_ff) begin
                len_ff <= {len_ff[15:8], rx_byte_ff};
                st_ff <= ST_CMD;
            end
        end
        ST_CMD: begin
            if (rx_vld_ff) begin
                cmd_ff <= rx_byte_ff;
                sum_ff <= rx_byte_ff;
                idx_ff <= 9'h000;
                if (rx_byte_ff == ufu_pkg::CMD_WRITE) begin
                    st_ff <= ST_DATA;
                end else begin
                    st_ff <= ST_SUM;
                end
            end
        end
        ST_DATA: begin
            if (rx_vld_ff) begin
                sum_ff <= sum_ff + rx_byte_ff;
                idx_ff <= idx_ff + 9'h001;
                if (idx_ff == ufu_pkg::PAYLOAD_BYTES - 9'h001) begin
                    st_ff <= ST_SUM;
                end
            end
        end
        ST_SUM: begin
            if (rx_vld_ff) begin
                idx_ff <= 9'h000;
                if (rx_byte_ff != sum_ff || !len_ok) begin
                    st_ff <= ST_ERR;
                end else if (cmd_ff == ufu_pkg::CMD_START) begin
                    led_ff <= 1'b0;
                    op_ff <= ufu_pkg::UFU_OP_INIT;
                    st_ff <= ST_OP;
                end else if (cmd_ff == ufu_pkg::CMD_WRITE
                        || cmd_ff == ufu_pkg::CMD_END) begin
                    st_ff <= ST_EXEC;
                end else begin
                    st_ff <= ST_ERR;
                end
            end
        end
        ST_EXEC: begin
            if (cmd_ff == ufu_pkg::CMD_END) begin
                op_ff <= blk_open_ff ? ufu_pkg::UFU_OP_VERIFY
                    : ufu_pkg::UFU_OP_BOOTINV;
            end else if (!blk_open_ff) begin
                op_ff <= ufu_pkg::UFU_OP_BLANK;
            end else begin
                op_ff <= ufu_pkg::UFU_OP_WRITE;
            end
            st_ff <= ST_OP;
        end
        ST_OP: begin
            req_ff <= 1'b1;
            st_ff <= ST_WAIT;
        end
        ST_WAIT: begin
            // Write op streams the buffer, one byte a cycle
            if (op_ff == ufu_pkg::UFU_OP_WRITE && idx_ff != 9'h0FF) begin
                idx_ff <= idx_ff + 9'h001;
            end
            if (is_fail) begin
                st_ff <= ST_ERR;
            end else if (fl_done) begin
                st_ff <= ST_NEXT;
            end
        end
        ST_NEXT: begin
            st_ff <= ST_OP;
            case (op_ff)
            ufu_pkg::UFU_OP_INIT: begin
                if (fl_shield_first_rd != ufu_pkg::SHIELD_FIRST
                        || fl_shield_last_rd != ufu_pkg::SHIELD_LAST) begin
                    op_ff <= ufu_pkg::UFU_OP_SHIELD;
                end else begin
                    addr_ff <= ufu_pkg::WRITE_BASE;
                    blk_open_ff <= 1'b0;
                    st_ff <= ST_ACK;
                end
            end
            ufu_pkg::UFU_OP_SHIELD: begin
                addr_ff <= ufu_pkg::WRITE_BASE;
                blk_open_ff <= 1'b0;
                st_ff <= ST_ACK;
            end
            ufu_pkg::UFU_OP_BLANK: begin
                blk_open_ff <= 1'b1;
                op_ff <= fl_blank ? ufu_pkg::UFU_OP_WRITE
                    : ufu_pkg::UFU_OP_ERASE;
            end
            ufu_pkg::UFU_OP_ERASE: begin
                op_ff <= ufu_pkg::UFU_OP_WRITE;
            end
            ufu_pkg::UFU_OP_WRITE: begin
                addr_ff <= addr_ff + ufu_pkg::WRITE_STEP;
                if (addr_ff[9:8] == 2'h3) begin
                    op_ff <= ufu_pkg::UFU_OP_VERIFY;
                end else begin
                    st_ff <= ST_ACK;
                end
            end
            ufu_pkg::UFU_OP_VERIFY: begin
                blk_open_ff <= 1'b0;
                if (cmd_ff == ufu_pkg::CMD_END) begin
                    op_ff <= ufu_pkg::UFU_OP_BOOTINV;
                end else begin
                    st_ff <= ST_ACK;
                end
            end
            default: begin
                led_ff <= 1'b1;
                st_ff <= ST_RESET;
            end
            endcase
        end
        ST_ACK: begin
            if (tx_go) begin
                st_ff <= ST_IDLE;
            end
        end
        ST_RESET: begin
            rst_ff <= 1'b1;
        end
        default: begin
            err_ff <= 1'b1;
        end
        endcase
    end
end
// Verify address uses the block just finished
logic [19:0] op_addr;
assign op_addr = (op_ff == ufu_pkg::UFU_OP_VERIFY && cmd_ff != ufu_pkg::CMD_END)
    ? addr_ff - ufu_pkg::WRITE_STEP : addr_ff;
always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        fl_windex <= 8'h00;
        fl_wdata <= 8'h00;
    end else begin
        fl_windex <= idx_ff[7:0];
        fl_wdata <= buf_mem[idx_ff[7:0]];
    end
end
assign fl_req = req_ff;
assign fl_op = op_ff;
assign fl_addr = op_addr;
assign fl_block = op_addr[ufu_pkg::BLOCK_SHIFT +: 6];
assign fl_shield_first = ufu_pkg::SHIELD_FIRST;
assign fl_shield_last = ufu_pkg::SHIELD_LAST;
assign flash_access_led_pin = led_ff;
assign error_flag = err_ff;
assign force_reset = rst_ff;
assign halt_req = (st_ff == ST_IDLE) && !rx_busy_ff;
// Boot flag value after inversion is applied by the sequencer
assign boot_swap_pending = !boot_flag_rd;
// ==========================================================
// Checks
a_ack_after_good: assert property (@(posedge sys_clk) disable iff (!rstn)
    tx_go |-> !err_ff && cmd_ff != ufu_pkg::CMD_END)
    else $error("reply sent for end or in error");
a_err_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    err_ff |=> err_ff && !tx_go)
    else $error("error state left");
a_fail_to_err: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_ff == ST_WAIT && is_fail) |=> ##1 err_ff)
    else $error("flash failure not flagged");
a_led_before_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(rst_ff) |-> flash_access_led_pin)
    else $error("reset with indicator on");
a_addr_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_ff == ST_NEXT && op_ff == ufu_pkg::UFU_OP_WRITE)
    |=> addr_ff == $past(addr_ff) + ufu_pkg::WRITE_STEP)
    else $error("address not advanced by 256");
a_init_base: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_ff == ST_ACK && cmd_ff == ufu_pkg::CMD_START)
    |-> addr_ff == ufu_pkg::WRITE_BASE)
    else $error("write base wrong at start ack");
a_bad_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st_ff == ST_IDLE && rx_vld_ff && rx_byte_ff != ufu_pkg::START_CODE)
    |=> ##1 err_ff)
    else $error("bad start code accepted");
a_led_on_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fl_req && fl_op == ufu_pkg::UFU_OP_INIT) |-> !flash_access_led_pin)
    else $error("init without indicator");
c_ack_sent: cover property (@(posedge sys_clk) disable iff (!rstn) tx_go);
c_erase: cover property (@(posedge sys_clk) disable iff (!rstn)
    fl_req && fl_op == ufu_pkg::UFU_OP_ERASE);
c_reset: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(rst_ff));
c_error: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(err_ff));
endmodule
`default_nettype wire

// ===== hdl/ufu_pkg.sv
package ufu_pkg;
    // Serial timing
    localparam int SYS_CLK_HZ = 100000000;
    localparam int BAUD_BPS = 115200;
    localparam int BIT_CYCLES = SYS_CLK_HZ / BAUD_BPS;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int DATA_BITS = 8;
    // Packet fields
    localparam logic [7:0] START_CODE = 8'h01;
    localparam logic [15:0] LEN_SHORT = 16'h0002;
    localparam logic [15:0] LEN_WRITE = 16'h0102;
    localparam logic [7:0] CMD_START = 8'h02;
    localparam logic [7:0] CMD_WRITE = 8'h03;
    localparam logic [7:0] CMD_END = 8'h04;
    localparam logic [8:0] PAYLOAD_BYTES = 9'h100;
    localparam logic [7:0] ACK_BYTE = 8'h01;
    // Flash layout
    localparam logic [19:0] WRITE_BASE = 20'h01000;
    localparam logic [19:0] WRITE_STEP = 20'h00100;
    localparam int BLOCK_SHIFT = 10;
    localparam logic [5:0] SHIELD_FIRST = 6'h00;
    localparam logic [5:0] SHIELD_LAST = 6'h3F;
    // Flash sequencer operations
    typedef enum logic [2:0] {
        UFU_OP_INIT = 3'h0,
        UFU_OP_SHIELD = 3'h1,
        UFU_OP_BLANK = 3'h2,
        UFU_OP_ERASE = 3'h3,
        UFU_OP_WRITE = 3'h4,
        UFU_OP_VERIFY = 3'h5,
        UFU_OP_BOOTINV = 3'h6,
        UFU_OP_NONE = 3'h7
    } ufu_op_t;
endpackage

// ===== test/ufu_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufu_host_model #(
    parameter int BIT_TICKS = ufu_pkg::BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic txd,
    output logic rxd
);
    // ========
    // Sender
    int rx_count;
    logic [7:0] rx_last;
    initial rxd = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frm;
        frm = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = frm[i];
            repeat (BIT_TICKS) @(negedge sys_clk);
        end
    endtask
    // Bad sum is inverted, so it never matches by wrap-around
    task automatic send_pkt(input logic [7:0] cmd, input logic [15:0] len,
                            input int n_data, input logic bad_sum);
        logic [7:0] sum;
        logic [7:0] d;
        sum = cmd;
        send_byte(ufu_pkg::START_CODE);
        send_byte(len[15:8]);
        send_byte(len[7:0]);
        send_byte(cmd);
        for (int i = 0; i < n_data; i++) begin
            d = i[7:0] ^ 8'hA5;
            sum = sum + d;
            send_byte(d);
        end
        send_byte(bad_sum ? ~sum : sum);
    endtask
    // ========
    // Receiver, mid-bit sampling
    initial begin
        rx_count = 0;
        rx_last = 8'h00;
        forever begin
            @(negedge txd);
            repeat (BIT_TICKS / 2) @(posedge sys_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_TICKS) @(posedge sys_clk);
                rx_last[i] = txd;
            end
            repeat (BIT_TICKS) @(posedge sys_clk);
            if (txd === 1'b1) rx_count++;
        end
    end
endmodule
`default_nettype wire

// ===== test/ufu_flash_update_cmd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
end
module ufu_flash_update_cmd_tb_top;
    // ========
    // Signals
    logic sys_clk = 1'b0, rstn = 1'b0, rxd, txd, led, err, halt, frst;
    logic swp, fl_req, fl_done = 1'b0, fl_fail = 1'b0, blank = 1'b1;
    logic boot = 1'b1, fail_en = 1'b0;
    logic [5:0] blk, sh_f, sh_l, sh_f_rd = 6'h05, sh_l_rd = 6'h14;
    logic [19:0] addr;
    logic [7:0] wi, wd;
    ufu_pkg::ufu_op_t op, cur_op, fail_op = ufu_pkg::UFU_OP_INIT;
    ufu_pkg::ufu_op_t op_log[$];
    logic [19:0] addr_log[$];
    logic [5:0] blk_log[$];
    // Short bit time keeps a 256-byte payload within the run budget
    localparam int BT = 4;
    int mismatches = 0, n_compared = 0, pend = 0, acks;
    always #5 sys_clk = ~sys_clk;
    ufu_flash_update_cmd #(.BIT_TICKS(BT)) dut_u (.sys_clk(sys_clk),
        .rstn(rstn), .rxd(rxd),
        .txd(txd), .flash_access_led_pin(led), .error_flag(err),
        .halt_req(halt), .force_reset(frst), .boot_swap_pending(swp),
        .fl_req(fl_req), .fl_op(op), .fl_addr(addr), .fl_block(blk),
        .fl_shield_first(sh_f), .fl_shield_last(sh_l), .fl_wdata(wd),
        .fl_windex(wi), .fl_done(fl_done), .fl_fail(fl_fail),
        .fl_blank(blank), .fl_shield_first_rd(sh_f_rd),
        .fl_shield_last_rd(sh_l_rd), .boot_flag_rd(boot));
    ufu_host_model #(.BIT_TICKS(BT)) host_u (.sys_clk(sys_clk), .txd(txd),
        .rxd(rxd));
    // ========
    // Flash sequencer stand-in; a write waits out the byte stream
    always @(negedge sys_clk) begin
        fl_done <= (pend == 1);
        fl_fail <= (pend == 1) && fail_en && (cur_op == fail_op);
        if (pend == 1 && cur_op == ufu_pkg::UFU_OP_BOOTINV) boot <= ~boot;
        if (pend == 1 && cur_op == ufu_pkg::UFU_OP_WRITE)
            `CHK("fl_windex", 8'hFF, wi)
        if (pend > 1 && cur_op == ufu_pkg::UFU_OP_WRITE)
            `CHK("fl_wdata", wi ^ 8'hA5, wd)
        if (fl_req === 1'b1) begin
            op_log.push_back(op);
            addr_log.push_back(addr);
            blk_log.push_back(blk);
            cur_op <= op;
            pend <= (op == ufu_pkg::UFU_OP_WRITE) ? 260 : 3;
        end else if (pend > 0) begin
            pend <= pend - 1;
        end
    end
    // ========
    // Tasks
    task automatic reset_dut();
        rstn = 1'b0;
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        op_log.delete();
        addr_log.delete();
        blk_log.delete();
        acks = host_u.rx_count;
    endtask
    task automatic expect_op(input ufu_pkg::ufu_op_t e, input logic [19:0] a,
                             input logic chk_a);
        ufu_pkg::ufu_op_t g;
        logic [19:0] ga;
        logic [5:0] gb;
        g = ufu_pkg::UFU_OP_NONE;
        ga = 20'h00000;
        gb = 6'h00;
        if (op_log.size() > 0) begin
            g = op_log.pop_front();
            ga = addr_log.pop_front();
            gb = blk_log.pop_front();
        end
        `CHK("fl_op", e, g)
        if (chk_a) `CHK("fl_addr", a, ga)
        if (chk_a) `CHK("fl_block", a[15:10], gb)
    endtask
    task automatic wait_acks(input int n);
        for (int i = 0; i < 2000 && host_u.rx_count < acks + n; i++)
            @(negedge sys_clk);
        `CHK("ack count", acks + n, host_u.rx_count)
        `CHK("ack byte", ufu_pkg::ACK_BYTE, host_u.rx_last)
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ========
    // Tests; about 60k cycles expected, watchdog allows 80k
    initial begin
        #800_000;
        mismatches++;
        complete_run();
    end
    initial begin
        reset_dut();
        `CHK("txd idle", 1'b1, txd)
        `CHK("led", 1'b1, led)
        `CHK("error", 1'b0, err)
        `CHK("force_reset", 1'b0, frst)
        `CHK("fl_op", ufu_pkg::UFU_OP_NONE, op)
        `CHK("halt", 1'b1, halt)
        $display("test reset done");
        host_u.send_pkt(ufu_pkg::CMD_START, ufu_pkg::LEN_SHORT, 0,
            1'b0);
        wait_acks(1);
        `CHK("led", 1'b0, led)
        expect_op(ufu_pkg::UFU_OP_INIT, 20'h0, 1'b0);
        expect_op(ufu_pkg::UFU_OP_SHIELD, 20'h0, 1'b0);
        `CHK("shield first", ufu_pkg::SHIELD_FIRST, sh_f)
        `CHK("shield last", ufu_pkg::SHIELD_LAST, sh_l)
        `CHK("swap", 1'b0, swp)
        $display("test start done");
        // Four writes fill a block; the fifth opens a blank one
        for (int k = 0; k < 5; k++) begin
            blank = (k == 4);
            host_u.send_pkt(ufu_pkg::CMD_WRITE, ufu_pkg::LEN_WRITE, 256,
                1'b0);
            wait_acks(k + 2);
        end
        expect_op(ufu_pkg::UFU_OP_BLANK, 20'h01000, 1'b1);
        expect_op(ufu_pkg::UFU_OP_ERASE, 20'h01000, 1'b1);
        expect_op(ufu_pkg::UFU_OP_WRITE, 20'h01000, 1'b1);
        expect_op(ufu_pkg::UFU_OP_WRITE, 20'h01100, 1'b1);
        expect_op(ufu_pkg::UFU_OP_WRITE, 20'h01200, 1'b1);
        expect_op(ufu_pkg::UFU_OP_WRITE, 20'h01300, 1'b1);
        expect_op(ufu_pkg::UFU_OP_VERIFY, 20'h01300, 1'b1);
        expect_op(ufu_pkg::UFU_OP_BLANK, 20'h01400, 1'b1);
        expect_op(ufu_pkg::UFU_OP_WRITE, 20'h01400, 1'b1);
        $display("test write done");
        host_u.send_pkt(ufu_pkg::CMD_END, ufu_pkg::LEN_SHORT, 0,
            1'b0);
        for (int i = 0; i < 200 && frst !== 1'b1; i++) @(negedge sys_clk);
        `CHK("force_reset", 1'b1, frst)
        `CHK("led", 1'b1, led)
        expect_op(ufu_pkg::UFU_OP_VERIFY, 20'h01500, 1'b1);
        expect_op(ufu_pkg::UFU_OP_BOOTINV, 20'h0, 1'b0);
        `CHK("swap", 1'b1, swp)
        repeat (400) @(negedge sys_clk);
        `CHK("end reply", acks + 6, host_u.rx_count)
        $display("test end done");
        reset_dut();
        host_u.send_pkt(ufu_pkg::CMD_START, ufu_pkg::LEN_SHORT, 0,
            1'b1);
        repeat (400) @(negedge sys_clk);
        `CHK("error", 1'b1, err)
        host_u.send_pkt(ufu_pkg::CMD_START, ufu_pkg::LEN_SHORT, 0,
            1'b0);
        repeat (400) @(negedge sys_clk);
        `CHK("ops", 0, op_log.size())
        `CHK("reply", acks, host_u.rx_count)
        $display("test sticky done");
        reset_dut();
        fail_en = 1'b1;
        host_u.send_pkt(ufu_pkg::CMD_START, ufu_pkg::LEN_SHORT, 0,
            1'b0);
        repeat (400) @(negedge sys_clk);
        expect_op(ufu_pkg::UFU_OP_INIT, 20'h0, 1'b0);
        `CHK("error", 1'b1, err)
        `CHK("reply", acks, host_u.rx_count)
        $display("test flash fail done");
        reset_dut();
        host_u.send_pkt(8'h05, ufu_pkg::LEN_SHORT, 0, 1'b0);
        repeat (400) @(negedge sys_clk);
        `CHK("error", 1'b1, err)
        `CHK("reply", acks, host_u.rx_count)
        reset_dut();
        host_u.send_byte(8'h55);
        repeat (400) @(negedge sys_clk);
        `CHK("error start code", 1'b1, err)
        reset_dut();
        host_u.send_pkt(ufu_pkg::CMD_START, ufu_pkg::LEN_WRITE, 0,
            1'b0);
        repeat (400) @(negedge sys_clk);
        `CHK("error length", 1'b1, err)
        `CHK("reply", acks, host_u.rx_count)
        $display("test bad packet done");
        complete_run();
    end
endmodule
`default_nettype wire
